// ---- hdl/scba_pkg.sv ----
// scba_pkg: constants shared by both ends of the sample clock and
// bus address configuration link.
// assumes a single 25 MHz system clock at both ends.
package scba_pkg;

    // system clock
    localparam longint CLK_HZ = 25000000;
    localparam int CLK_PERIOD_NS = 40;

    // external clock as applied to the pin, and its halved rate
    localparam longint EXT_CLK_HZ = 4096000;
    localparam longint HALF_CLK_HZ = EXT_CLK_HZ / 2;

    // phase accumulators used for the oscillator and the host clock source
    localparam int ACC_W = 16;
    localparam longint ACC_SPAN = 65536;

    // samples per row, and the oscillator-to-sample ratio in internal mode
    localparam int ROW_SAMPLES = 2048;
    localparam int ROW_W = 11;
    localparam int OSC_PER_SAMPLE = 256;
    localparam int DIV_W = 10;

    // pin must stay low this long before internal mode is taken
    localparam int EXT_IDLE_NS = 2000;
    localparam int EXT_IDLE_CYC =
        (EXT_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int IDLE_W = 7;

    // sample rates in Hz for codes 00..11
    localparam longint RATE_HZ [4] = '{8000, 6400, 5300, 4000};

    // rates and filter knees in units of 100 Hz for codes 00..11
    localparam logic [7:0] RATE_100HZ [4] = '{8'h50, 8'h40, 8'h35, 8'h28};
    localparam logic [7:0] KNEE_100HZ [4] = '{8'h22, 8'h1b, 8'h17, 8'h11};

    // fixed upper part of the 7-bit slave address
    localparam logic [4:0] ADDR_FIXED = 5'h10;
    localparam int ADDR_W = 7;

    // read/write bit values in the address byte
    localparam logic RW_WRITE = 1'b0;
    localparam logic RW_READ = 1'b1;

    // host: toggle rate of the pin is twice the external clock
    localparam logic [ACC_W-1:0] EXT_TOGGLE_INC =
        ACC_W'((EXT_CLK_HZ * 2 * ACC_SPAN) / CLK_HZ);

endpackage : scba_pkg

// ---- hdl/scba_link_if.sv ----
// scba_link_if: pins between the device end and the host end.
// assumes both ends sit on the same system clock; no clocking block.
`timescale 1ns/1ps
`default_nettype none
interface scba_link_if;
    logic ext_clock_in;
    logic rate_sel_hi;
    logic rate_sel_lo;
    logic addr_strap_hi;
    logic addr_strap_lo;
    logic [7:0] addr_byte;
    logic addr_valid;
    logic resp_valid;
    logic resp_match;
    logic resp_read;

    modport dev (
        input ext_clock_in,
        input rate_sel_hi,
        input rate_sel_lo,
        input addr_strap_hi,
        input addr_strap_lo,
        input addr_byte,
        input addr_valid,
        output resp_valid,
        output resp_match,
        output resp_read
    );

    modport host (
        output ext_clock_in,
        output rate_sel_hi,
        output rate_sel_lo,
        output addr_strap_hi,
        output addr_strap_lo,
        output addr_byte,
        output addr_valid,
        input resp_valid,
        input resp_match,
        input resp_read
    );
endinterface : scba_link_if
`default_nettype wire

// ---- hdl/scba_device.sv ----
// scba_device: timing source selection, sample and row timing, filter
// knee report and slave address decode of the documented device.
// assumes the host end drives the link on the same clk_i.
//
// Notes on behaviour
// - host grounds clock pin for internal oscillator.
// - internal oscillator runs at four selectable rates.
// - host applies 4.096 MHz in external mode.
// - filter knee follows rate field; host programs it.
// - external clock is halved immediately.
// - 7-bit address, two low bits from straps.
// - address byte is 10000, straps, rw bit.
// - hosts give each device distinct straps.
`timescale 1ns/1ps
`default_nettype none
module scba_device #(
    parameter int IDLE_CYC = scba_pkg::EXT_IDLE_CYC,
    parameter int ROW_LEN = scba_pkg::ROW_SAMPLES
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // link to the host
    scba_link_if.dev link,
    // timing outputs
    output logic sample_tick_o,
    output logic row_tick_o,
    output logic ext_mode_o,
    // configuration report
    output logic [1:0] rate_sel_o,
    output logic [7:0] rate_100hz_o,
    output logic [7:0] knee_100hz_o,
    output logic [6:0] slave_addr_o
);

    // oscillator increments: oscillator runs at 256 times the sample rate
    localparam logic [scba_pkg::ACC_W-1:0] OSC_INC [4] = '{
        scba_pkg::ACC_W'((scba_pkg::RATE_HZ[0] * scba_pkg::OSC_PER_SAMPLE
            * scba_pkg::ACC_SPAN) / scba_pkg::CLK_HZ),
        scba_pkg::ACC_W'((scba_pkg::RATE_HZ[1] * scba_pkg::OSC_PER_SAMPLE
            * scba_pkg::ACC_SPAN) / scba_pkg::CLK_HZ),
        scba_pkg::ACC_W'((scba_pkg::RATE_HZ[2] * scba_pkg::OSC_PER_SAMPLE
            * scba_pkg::ACC_SPAN) / scba_pkg::CLK_HZ),
        scba_pkg::ACC_W'((scba_pkg::RATE_HZ[3] * scba_pkg::OSC_PER_SAMPLE
            * scba_pkg::ACC_SPAN) / scba_pkg::CLK_HZ)
    };

    // halved external clock ticks per sample, per rate code
    localparam logic [scba_pkg::DIV_W-1:0] EXT_DIV [4] = '{
        scba_pkg::DIV_W'(scba_pkg::HALF_CLK_HZ / scba_pkg::RATE_HZ[0]),
        scba_pkg::DIV_W'(scba_pkg::HALF_CLK_HZ / scba_pkg::RATE_HZ[1]),
        scba_pkg::DIV_W'(scba_pkg::HALF_CLK_HZ / scba_pkg::RATE_HZ[2]),
        scba_pkg::DIV_W'(scba_pkg::HALF_CLK_HZ / scba_pkg::RATE_HZ[3])
    };
    localparam logic [scba_pkg::DIV_W-1:0] INT_DIV =
        scba_pkg::DIV_W'(scba_pkg::OSC_PER_SAMPLE);
    localparam logic [scba_pkg::IDLE_W-1:0] IDLE_LIM =
        scba_pkg::IDLE_W'(IDLE_CYC);
    localparam logic [scba_pkg::ROW_W-1:0] ROW_LAST =
        scba_pkg::ROW_W'(ROW_LEN - 1);

    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic ext_rise;
    logic half_q;
    logic half_tick;
    logic [scba_pkg::IDLE_W-1:0] idle_cnt_q;
    logic ext_mode_q;
    logic mode_change;
    logic [1:0] rate_q;
    logic strap_s1_q [2];
    logic strap_s2_q [2];
    logic [scba_pkg::ACC_W:0] osc_sum;
    logic [scba_pkg::ACC_W-1:0] osc_acc_q;
    logic osc_tick;
    logic base_tick;
    logic [scba_pkg::DIV_W-1:0] div_lim;
    logic [scba_pkg::DIV_W-1:0] div_cnt_q;
    logic samp_hit;
    logic [scba_pkg::ROW_W-1:0] row_cnt_q;
    logic [6:0] own_addr;
    logic resp_valid_q;
    logic resp_match_q;
    logic resp_read_q;

    // the pin is a foreign clock: two flops before any logic, third for edge
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
        end else begin
            ext_s1_q <= link.ext_clock_in;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
        end
    end
    assign ext_rise = ext_s2_q & ~ext_s3_q;

    // divide by two at once, so only rising edges matter, not duty cycle
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            half_q <= 1'b0;
        end else if (ext_rise) begin
            half_q <= ~half_q;
        end
    end
    assign half_tick = ext_rise & half_q;

    // a pin held low for the idle time selects internal mode
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            // pin counts as grounded until it moves: no false external spell
            idle_cnt_q <= IDLE_LIM;
            ext_mode_q <= 1'b0;
        end else begin
            if (ext_s2_q) begin
                idle_cnt_q <= '0;
            end else if (idle_cnt_q != IDLE_LIM) begin
                idle_cnt_q <= idle_cnt_q + 1'b1;
            end
            ext_mode_q <= ext_s2_q || (idle_cnt_q != IDLE_LIM);
        end
    end
    assign mode_change = ext_mode_q != (ext_s2_q || (idle_cnt_q != IDLE_LIM));

    // rate field comes from same-clock logic; straps are pins
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rate_q <= 2'h0;
        end else begin
            rate_q <= {link.rate_sel_hi, link.rate_sel_lo};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            strap_s1_q <= '{1'b0, 1'b0};
            strap_s2_q <= '{1'b0, 1'b0};
        end else begin
            strap_s1_q <= '{link.addr_strap_hi, link.addr_strap_lo};
            strap_s2_q <= strap_s1_q;
        end
    end

    // internal oscillator: carry of a phase accumulator, rate by code
    assign osc_sum = {1'b0, osc_acc_q} + {1'b0, OSC_INC[rate_q]};
    assign osc_tick = osc_sum[scba_pkg::ACC_W];

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            osc_acc_q <= '0;
        end else if (ext_mode_q) begin
            osc_acc_q <= '0;
        end else begin
            osc_acc_q <= osc_sum[scba_pkg::ACC_W-1:0];
        end
    end

    // one timing source at a time; counters restart on a mode change
    assign base_tick = ext_mode_q ? half_tick : osc_tick;
    assign div_lim = ext_mode_q ? EXT_DIV[rate_q] : INT_DIV;
    assign samp_hit = base_tick && (div_cnt_q >= div_lim - 1'b1);

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            div_cnt_q <= '0;
        end else if (mode_change || samp_hit) begin
            div_cnt_q <= '0;
        end else if (base_tick) begin
            div_cnt_q <= div_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            row_cnt_q <= '0;
        end else if (mode_change) begin
            row_cnt_q <= '0;
        end else if (samp_hit && row_cnt_q == ROW_LAST) begin
            row_cnt_q <= '0;
        end else if (samp_hit) begin
            row_cnt_q <= row_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            sample_tick_o <= 1'b0;
            row_tick_o <= 1'b0;
            ext_mode_o <= 1'b0;
        end else begin
            sample_tick_o <= samp_hit && !mode_change;
            row_tick_o <= samp_hit && !mode_change && (row_cnt_q == ROW_LAST);
            ext_mode_o <= ext_mode_q;
        end
    end

    // reported rate and filter knee track the field in both modes
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rate_sel_o <= 2'h0;
            rate_100hz_o <= scba_pkg::RATE_100HZ[0];
            knee_100hz_o <= scba_pkg::KNEE_100HZ[0];
        end else begin
            rate_sel_o <= rate_q;
            rate_100hz_o <= scba_pkg::RATE_100HZ[rate_q];
            knee_100hz_o <= scba_pkg::KNEE_100HZ[rate_q];
        end
    end

    // address: fixed upper bits, straps as the two lowest
    assign own_addr = {scba_pkg::ADDR_FIXED, strap_s2_q[0],
        strap_s2_q[1]};

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            slave_addr_o <= {scba_pkg::ADDR_FIXED, 2'h0};
        end else begin
            slave_addr_o <= own_addr;
        end
    end

    // answer every address byte one cycle later with match and direction
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            resp_valid_q <= 1'b0;
            resp_match_q <= 1'b0;
            resp_read_q <= 1'b0;
        end else begin
            resp_valid_q <= link.addr_valid;
            if (link.addr_valid) begin
                resp_match_q <= link.addr_byte[7:1] == own_addr;
                resp_read_q <= link.addr_byte[0] == scba_pkg::RW_READ;
            end
        end
    end

    assign link.resp_valid = resp_valid_q;
    assign link.resp_match = resp_match_q;
    assign link.resp_read = resp_read_q;

endmodule : scba_device
`default_nettype wire

// ---- hdl/scba_host.sv ----
// scba_host: the party outside the device; applies the clock, the rate
// field and the straps, and sends address bytes.
// assumes the device end answers each address byte one cycle later.
`timescale 1ns/1ps
`default_nettype none
module scba_host (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // link to the device
    scba_link_if.host link,
    // configuration
    input wire logic ext_clk_en_i,
    input wire logic [1:0] rate_sel_i,
    input wire logic [1:0] strap_i,
    // address probe
    input wire logic probe_req_i,
    input wire logic [1:0] probe_target_i,
    input wire logic probe_read_i,
    output logic probe_busy_o,
    output logic probe_done_o,
    output logic probe_match_o,
    output logic probe_read_o
);

    typedef enum logic [1:0] {
        SCBA_IDLE,
        SCBA_SEND,
        SCBA_WAIT
    } scba_host_state_t;

    scba_host_state_t state_q;
    logic [scba_pkg::ACC_W:0] clk_sum;
    logic [scba_pkg::ACC_W-1:0] clk_acc_q;
    logic ext_pin_q;
    logic [1:0] rate_q;
    logic [1:0] strap_q;
    logic [7:0] byte_q;
    logic valid_q;

    // pin toggles at twice 4.096 MHz on average; jitter is one clk_i period
    assign clk_sum = {1'b0, clk_acc_q} + {1'b0, scba_pkg::EXT_TOGGLE_INC};

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            clk_acc_q <= '0;
            ext_pin_q <= 1'b0;
        end else if (!ext_clk_en_i) begin
            clk_acc_q <= '0;
            ext_pin_q <= 1'b0;
        end else begin
            clk_acc_q <= clk_sum[scba_pkg::ACC_W-1:0];
            if (clk_sum[scba_pkg::ACC_W]) begin
                ext_pin_q <= ~ext_pin_q;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            rate_q <= 2'h0;
            strap_q <= 2'h0;
        end else begin
            rate_q <= rate_sel_i;
            strap_q <= strap_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_q <= SCBA_IDLE;
            byte_q <= 8'h00;
            valid_q <= 1'b0;
            probe_busy_o <= 1'b0;
            probe_done_o <= 1'b0;
            probe_match_o <= 1'b0;
            probe_read_o <= 1'b0;
        end else begin
            probe_done_o <= 1'b0;
            valid_q <= 1'b0;
            unique case (state_q)
                SCBA_IDLE: begin
                    if (probe_req_i) begin
                        byte_q <= {scba_pkg::ADDR_FIXED, probe_target_i,
                            probe_read_i ? scba_pkg::RW_READ
                                         : scba_pkg::RW_WRITE};
                        valid_q <= 1'b1;
                        probe_busy_o <= 1'b1;
                        state_q <= SCBA_SEND;
                    end
                end
                SCBA_SEND: begin
                    state_q <= SCBA_WAIT;
                end
                SCBA_WAIT: begin
                    if (link.resp_valid) begin
                        probe_match_o <= link.resp_match;
                        probe_read_o <= link.resp_read;
                        probe_done_o <= 1'b1;
                        probe_busy_o <= 1'b0;
                        state_q <= SCBA_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.ext_clock_in = ext_pin_q;
    assign link.rate_sel_hi = rate_q[1];
    assign link.rate_sel_lo = rate_q[0];
    assign link.addr_strap_hi = strap_q[1];
    assign link.addr_strap_lo = strap_q[0];
    assign link.addr_byte = byte_q;
    assign link.addr_valid = valid_q;

endmodule : scba_host
`default_nettype wire

// ---- verif/scba_link_chk.sv ----
// scba_link_chk: assertions on the pins between the two ends.
// assumes the bench instantiates it beside the link, on the same clock.
`timescale 1ns/1ps
`default_nettype none
module scba_link_chk (
    // clock and reset
    input wire logic clk_i,
    input wire logic resetn_i,
    // link signals
    input wire logic ext_clock_in,
    input wire logic addr_strap_hi,
    input wire logic addr_strap_lo,
    input wire logic [7:0] addr_byte,
    input wire logic addr_valid,
    input wire logic resp_valid,
    input wire logic resp_match,
    input wire logic resp_read
);
    logic [2:0] calm_q;
    logic [1:0] strap_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);

    // the device syncs straps, so decode is judged only once they settle
    always_ff @(posedge clk_i) begin
        strap_q <= {addr_strap_hi, addr_strap_lo};
        if (!resetn_i || strap_q != {addr_strap_hi, addr_strap_lo}) begin
            calm_q <= 3'h0;
        end else if (calm_q != 3'h7) begin
            calm_q <= calm_q + 3'h1;
        end
    end

    a_resp_next_cycle: assert property (
        addr_valid |=> resp_valid)
        else $error("no answer one cycle after an address byte");
    a_resp_has_cause: assert property (
        resp_valid |-> $past(addr_valid))
        else $error("answer without an address byte");
    a_match_decode: assert property (
        addr_valid && calm_q >= 3'h4 |=> resp_match ==
        ($past(addr_byte[7:1]) == {scba_pkg::ADDR_FIXED, $past(strap_q)}))
        else $error("address decode wrong");
    a_read_bit: assert property (
        addr_valid |=> resp_read == $past(addr_byte[0]))
        else $error("read bit not returned");
    a_byte_upper_fixed: assert property (
        addr_valid |-> addr_byte[7:3] == scba_pkg::ADDR_FIXED)
        else $error("address byte upper bits wrong");
    a_match_held: assert property (
        $changed(resp_match) || $changed(resp_read) |-> resp_valid)
        else $error("answer changed without a byte");
    a_byte_pulse: assert property (
        addr_valid |=> !addr_valid ##1 !addr_valid)
        else $error("address bytes too close");
    a_pin_high_short: assert property (
        $rose(ext_clock_in) |-> ##[1:4] !ext_clock_in)
        else $error("clock pin high too long");

    c_match: cover property (resp_valid && resp_match && resp_read);
    c_miss: cover property (resp_valid && !resp_match);
    c_pin: cover property ($rose(ext_clock_in));
endmodule : scba_link_chk
`default_nettype wire

// ---- verif/test_sample_clock_and_bus_address_config.sv ----
// test_sample_clock_and_bus_address_config: both ends joined by the link.
// assumes a 25 MHz clock; idle count cut to 8 cycles, rows to 2 samples.
`timescale 1ns/1ps
`default_nettype none
module test_sample_clock_and_bus_address_config;
    logic clk_i;
    logic resetn_i;
    logic ext_clk_en;
    logic [1:0] rate_sel;
    logic [1:0] strap;
    logic probe_req;
    logic [1:0] probe_target;
    logic probe_read;
    logic probe_busy, probe_done, probe_match, probe_rd;
    logic sample_tick, row_tick, ext_mode;
    logic [1:0] rate_sel_o;
    logic [7:0] rate_100hz, knee_100hz;
    logic [6:0] slave_addr;
    int num_errors = 0;
    int check_count = 0;
    int n;
    logic [3:0] rows;

    scba_link_if link_if ();
    scba_device #(.IDLE_CYC(8), .ROW_LEN(2)) i_scba_device (.clk_i(clk_i),
        .resetn_i(resetn_i), .link(link_if), .sample_tick_o(sample_tick),
        .row_tick_o(row_tick), .ext_mode_o(ext_mode),
        .rate_sel_o(rate_sel_o), .rate_100hz_o(rate_100hz),
        .knee_100hz_o(knee_100hz), .slave_addr_o(slave_addr));
    scba_host i_scba_host (.clk_i(clk_i), .resetn_i(resetn_i),
        .link(link_if), .ext_clk_en_i(ext_clk_en), .rate_sel_i(rate_sel),
        .strap_i(strap), .probe_req_i(probe_req),
        .probe_target_i(probe_target), .probe_read_i(probe_read),
        .probe_busy_o(probe_busy), .probe_done_o(probe_done),
        .probe_match_o(probe_match), .probe_read_o(probe_rd));
    scba_link_chk i_scba_link_chk (.clk_i(clk_i), .resetn_i(resetn_i),
        .ext_clock_in(link_if.ext_clock_in),
        .addr_strap_hi(link_if.addr_strap_hi),
        .addr_strap_lo(link_if.addr_strap_lo),
        .addr_byte(link_if.addr_byte), .addr_valid(link_if.addr_valid),
        .resp_valid(link_if.resp_valid), .resp_match(link_if.resp_match),
        .resp_read(link_if.resp_read));

    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    task automatic step(input int k);
        repeat (k) @(posedge clk_i);
        #1;
    endtask : step

    task automatic check_val(input string what, input logic [7:0] exp,
            input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check_val

    task automatic check_span(input string what, input int exp,
            input int got);
        check_count++;
        if (got < exp - exp / 64 || got > exp + exp / 64) begin
            num_errors++;
            $display("Error %s expected %0d seen %0d", what, exp, got);
        end
    endtask : check_span

    // counts cycles up to the next sample tick; bounded so a dead
    // divider shows up as a wrong span rather than a hang
    task automatic wait_tick(output int k);
        k = 0;
        do begin
            step(1);
            k++;
        end while (sample_tick !== 1'b1 && k < 20000);
    endtask : wait_tick

    // first tick after a change is discarded: it may span two settings
    task automatic measure(output int k);
        wait_tick(k);
        wait_tick(k);
    endtask : measure

    task automatic probe(input logic [1:0] t, input logic rd);
        int k;
        probe_target = t;
        probe_read = rd;
        probe_req = 1'b1;
        step(1);
        probe_req = 1'b0;
        check_val("probe_busy", 8'h01, {7'h0, probe_busy});
        k = 0;
        while (probe_done !== 1'b1 && k < 20) begin
            step(1);
            k++;
        end
        check_val("probe_done", 8'h01, {7'h0, probe_done});
    endtask : probe

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #(95000 * 40);
        num_errors++;
        $display("Error watchdog expected end seen timeout");
        print_verdict();
    end

    initial begin
        resetn_i = 1'b0;
        ext_clk_en = 1'b0;
        rate_sel = 2'h0;
        strap = 2'h0;
        probe_req = 1'b0;
        probe_target = 2'h0;
        probe_read = 1'b0;
        step(4);
        check_val("rate", 8'h50, rate_100hz);
        check_val("knee", 8'h22, knee_100hz);
        check_val("slave_addr", 8'h40, {1'b0, slave_addr});
        resetn_i = 1'b1;
        $display("test reset done");
        for (int s = 0; s < 4; s++) begin
            strap = 2'(s);
            step(8);
            check_val("slave_addr", {1'b0, scba_pkg::ADDR_FIXED, 2'(s)},
                {1'b0, slave_addr});
            for (int t = 0; t < 8; t++) begin
                probe(2'(t / 2), t[0]);
                check_val("match", {7'h0, t / 2 == s},
                    {7'h0, probe_match});
                check_val("read", {7'h0, t[0]}, {7'h0, probe_rd});
            end
        end
        $display("test addressing done");
        for (int c = 0; c < 4; c++) begin
            rate_sel = 2'(c);
            step(8);
            check_val("rate_sel", 8'(c), {6'h0, rate_sel_o});
            check_val("rate", scba_pkg::RATE_100HZ[c], rate_100hz);
            check_val("knee", scba_pkg::KNEE_100HZ[c], knee_100hz);
            measure(n);
            check_span("span",
                int'(scba_pkg::CLK_HZ / scba_pkg::RATE_HZ[c]), n);
        end
        $display("test internal rates done");
        for (int c = 0; c < 4; c++) begin
            rate_sel = 2'(c);
            step(8);
            ext_clk_en = 1'b1;
            step(20);
            check_val("ext_mode", 8'h01, {7'h0, ext_mode});
            measure(n);
            check_span("span",
                int'(scba_pkg::CLK_HZ / scba_pkg::RATE_HZ[c]), n);
            ext_clk_en = 1'b0;
            step(30);
            check_val("ext_mode", 8'h00, {7'h0, ext_mode});
        end
        $display("test external clock done");
        // the mode change just above restarted the row count
        rate_sel = 2'h0;
        rows = 4'h0;
        for (int r = 0; r < 4; r++) begin
            wait_tick(n);
            rows = {rows[2:0], row_tick};
        end
        check_val("row_ticks", 8'h05, {4'h0, rows});
        $display("test row timing done");
        print_verdict();
    end
endmodule : test_sample_clock_and_bus_address_config
`default_nettype wire
